// file: src/rsq_top.sv
`timescale 1ns/1ps
`include "rsq_regs.svh"

// What this block does
// - Low external reset pin holds system reset and initialises all units.
// - Pin going low to high ends the pin reset.
// - Low pulses on the reset pin shorter than 60 ns are ignored.
// - Main and internal oscillators stop in reset; subclock and RTC keep running.
// - Peripheral clocks stay off until the stabilisation wait has finished.
// - System and CPU clocks resume with divider initialised to divide by 8.
// - CPU held in reset, fetches from address zero after stabilisation.
// - Watchdog counter cleared in reset, counts from zero once reset ends.
// - RAM kept across reset unless power-on or an access meets reset.
// - All I/O lines go high impedance while reset is active.
// - Pin reset restores peripheral defaults and sets debug control to 01H.
// - Debug enable bit plus high debug reset pin enters debug mode.
// - Watchdog overflow in reset mode triggers a full system reset.
// - Watchdog reset lasts a fixed time then releases on its own.
// - Watchdog reset reinitialises peripherals but keeps debug control.
// - Other peripheral functions stay stopped until stabilisation completes.
// - Pin reset clears cause register; other sources set own flag.
// - Cause flags clear only by writing zero or by pin reset; a set beats a clear.
module rsq_top
	import rsq_pkg::*;
#(
	parameter int STAB_CYCLES = `RSQ_STAB_CYCLES,
	parameter int WDT_HOLD_CYCLES = `RSQ_WDT_HOLD_CYCLES,
	parameter int CNT_W = 16
)
(
	// Clock and power-on reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reset sources
	input wire logic ext_reset_n_pin,
	input wire logic watchdog_reset_request,
	input wire logic low_voltage_event,
	input wire logic clock_monitor_event,
	// Debug and memory observation
	input wire logic debug_reset_pin,
	input wire logic cpu_mem_access,
	// System controls
	output logic sys_reset_n,
	output logic io_hiz,
	output logic wdt_clear,
	output logic wdt_run,
	output logic debug_mode_entry,
	output rsq_clk_ctl_s clk_ctl,
	output rsq_cpu_ctl_s cpu_ctl
);

	// ----------------------------------------------------------------
	// Constants
	// ----------------------------------------------------------------
	localparam logic [3:0] FILT_CYCLES = 4'(`RSQ_FILT_CYCLES);
	localparam logic [CNT_W-1:0] STAB_LAST = CNT_W'(STAB_CYCLES - 1);
	localparam logic [CNT_W-1:0] WDT_LAST = CNT_W'(WDT_HOLD_CYCLES - 1);

	// ----------------------------------------------------------------
	// Decode helper
	// ----------------------------------------------------------------
	function automatic rsq_dec_s dec_addr(input logic [11:0] a);
		rsq_dec_s d;
		d.valid = (a[11:4] == 8'h00) && (a[1:0] == 2'h0);
		d.idx = a[3:2];
		return d;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic rst_pin_s1_q;
	logic rst_pin_s2_q;
	logic dbg_pin_s1_q;
	logic dbg_pin_s2_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rst_pin_s1_q <= 1'b1;
			rst_pin_s2_q <= 1'b1;
			dbg_pin_s1_q <= 1'b0;
			dbg_pin_s2_q <= 1'b0;
		end
		else
		begin
			rst_pin_s1_q <= ext_reset_n_pin;
			rst_pin_s2_q <= rst_pin_s1_q;
			dbg_pin_s1_q <= debug_reset_pin;
			dbg_pin_s2_q <= dbg_pin_s1_q;
		end
	end

	// ----------------------------------------------------------------
	// Noise filter
	// ----------------------------------------------------------------
	logic [3:0] low_cnt_q;
	logic [3:0] low_cnt_d;
	wire pin_low;

	assign low_cnt_d = rst_pin_s2_q ? 4'h0 : ((low_cnt_q >= FILT_CYCLES) ? low_cnt_q : low_cnt_q + 4'h1);
	assign pin_low = (low_cnt_q >= FILT_CYCLES) && !rst_pin_s2_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			low_cnt_q <= 4'h0;
		else
			low_cnt_q <= low_cnt_d;
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	rsq_state_e state_q;
	rsq_state_e state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [7:0] ctrl_q;
	wire wdt_mode;
	wire wdt_hit;
	wire hold_q;
	wire hold_d;
	wire run_d;

	assign wdt_mode = ctrl_q[`RSQ_CTRL_WDT_MODE_BIT];
	// overflow honoured only in reset mode
	assign wdt_hit = watchdog_reset_request && wdt_mode && (state_q == RSQ_ST_RUN || state_q == RSQ_ST_STAB);
	assign hold_q = (state_q == RSQ_ST_PIN_HOLD) || (state_q == RSQ_ST_WDT_HOLD);
	assign hold_d = (state_d == RSQ_ST_PIN_HOLD) || (state_d == RSQ_ST_WDT_HOLD);
	assign run_d = (state_d == RSQ_ST_RUN);

	always_comb
	begin
		state_d = state_q;
		cnt_d = cnt_q;
		case (state_q)
			RSQ_ST_PIN_HOLD:
			begin
				cnt_d = '0;
				if (!pin_low)
					state_d = RSQ_ST_STAB;
			end
			RSQ_ST_WDT_HOLD:
			begin
				cnt_d = cnt_q + CNT_W'(1);
				if (cnt_q == WDT_LAST)
				begin
					state_d = RSQ_ST_STAB;
					cnt_d = '0;
				end
			end
			RSQ_ST_STAB:
			begin
				cnt_d = cnt_q + CNT_W'(1);
				if (cnt_q == STAB_LAST)
				begin
					state_d = RSQ_ST_RUN;
					cnt_d = '0;
				end
			end
			RSQ_ST_RUN:
			begin
				cnt_d = '0;
			end
			default:
			begin
				state_d = RSQ_ST_PIN_HOLD;
				cnt_d = '0;
			end
		endcase
		if (wdt_hit)
		begin
			state_d = RSQ_ST_WDT_HOLD;
			cnt_d = '0;
		end
		// The pin outranks every other source
		if (pin_low)
		begin
			state_d = RSQ_ST_PIN_HOLD;
			cnt_d = '0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= RSQ_ST_PIN_HOLD;
			cnt_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// ----------------------------------------------------------------
	// Registered system controls
	// ----------------------------------------------------------------
	rsq_clk_ctl_s clk_ctl_d;
	rsq_cpu_ctl_s cpu_ctl_d;
	logic dbg_entry_d;

	// only main and internal oscillators stop
	assign clk_ctl_d.main_osc_en = !hold_d;
	assign clk_ctl_d.int_osc_en = !hold_d;
	assign clk_ctl_d.sub_osc_en = 1'b1;
	assign clk_ctl_d.rtc_run = 1'b1;
	assign clk_ctl_d.periph_clk_en = run_d;
	assign clk_ctl_d.sys_clk_en = run_d;
	// divider comes out of reset at divide by 8
	assign clk_ctl_d.cpu_div = hold_d ? `RSQ_DIV8 : ctrl_q[`RSQ_CTRL_DIV_LSB +: 3];
	// CPU starts at the reset vector
	assign cpu_ctl_d.cpu_hold = !run_d;
	assign cpu_ctl_d.cpu_start = run_d && (state_q != RSQ_ST_RUN);
	assign cpu_ctl_d.reset_vec = `RSQ_CPU_RESET_VEC;

	logic [7:0] debug_q;
	// latch debug entry once out of reset
	assign dbg_entry_d = (state_q == RSQ_ST_PIN_HOLD) ? 1'b0
		: (debug_mode_entry || (!hold_q && debug_q[`RSQ_DEBUG_EN_BIT] && dbg_pin_s2_q));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_ctl <= '{main_osc_en: 1'b0, int_osc_en: 1'b0, sub_osc_en: 1'b1, rtc_run: 1'b1,
				periph_clk_en: 1'b0, sys_clk_en: 1'b0, cpu_div: `RSQ_DIV8};
			cpu_ctl <= '{cpu_hold: 1'b1, cpu_start: 1'b0, reset_vec: `RSQ_CPU_RESET_VEC};
			sys_reset_n <= 1'b0;
			io_hiz <= 1'b1;
			wdt_clear <= 1'b1;
			wdt_run <= 1'b0;
			debug_mode_entry <= 1'b0;
		end
		else
		begin
			clk_ctl <= clk_ctl_d;
			cpu_ctl <= cpu_ctl_d;
			sys_reset_n <= !hold_d;
			io_hiz <= hold_d;
			// watchdog cleared, then counts at once
			wdt_clear <= hold_d;
			wdt_run <= !hold_d;
			debug_mode_entry <= dbg_entry_d;
		end
	end

	// ----------------------------------------------------------------
	// APB access
	// ----------------------------------------------------------------
	rsq_dec_s setup_dec;
	rsq_dec_s acc_dec;
	wire setup;
	wire wr;
	wire wr_cause;
	wire wr_debug;
	wire wr_ctrl;
	wire wr_stat;

	assign setup = psel && !penable;
	assign setup_dec = dec_addr(paddr);
	assign acc_dec = dec_addr(paddr);
	// Zero-wait access; read data is captured in the setup cycle
	assign pready = psel && penable;
	assign wr = psel && penable && pwrite && acc_dec.valid;
	assign wr_cause = wr && (paddr == `RSQ_CAUSE_OFFS);
	assign wr_debug = wr && (paddr == `RSQ_DEBUG_OFFS);
	assign wr_ctrl = wr && (paddr == `RSQ_CTRL_OFFS);
	assign wr_stat = wr && (paddr == `RSQ_STAT_OFFS);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [7:0] cause_q;
	logic [7:0] cause_d;
	logic [7:0] cause_set;
	logic [7:0] debug_d;
	logic [7:0] ctrl_d;
	logic ram_sus_q;
	logic ram_sus_d;
	logic [7:0] stat_rd;
	logic [31:0] rd_mux;

	assign cause_set = {3'h0, wdt_hit, 2'h0, clock_monitor_event, low_voltage_event} & `RSQ_CAUSE_MASK;

	always_comb
	begin
		cause_d = cause_q;
		if (pin_low)
			cause_d = `RSQ_CAUSE_RST;
		// only zeros clear, writing one does nothing
		else if (wr_cause)
			cause_d = cause_q & pwdata[7:0];
		cause_d = cause_d | cause_set;
	end

	assign debug_d = (state_q == RSQ_ST_PIN_HOLD) ? `RSQ_DEBUG_PIN_RST
		: (wr_debug ? {7'h00, pwdata[`RSQ_DEBUG_EN_BIT]} : debug_q);
	// peripheral setup returns to defaults in any reset
	assign ctrl_d = hold_q ? `RSQ_CTRL_RST : (wr_ctrl ? pwdata[7:0] & 8'h71 : ctrl_q);

	// flag RAM as suspect when an access meets reset entry
	assign ram_sus_d = (hold_d && !hold_q && cpu_mem_access)
		|| (ram_sus_q && !(wr_stat && pwdata[`RSQ_STAT_RAM_BIT]));

	assign stat_rd = {2'h0, state_q, 1'b0, debug_mode_entry, sys_reset_n, ram_sus_q};
	assign rd_mux = (setup_dec.idx == 2'h0) ? {24'h0, cause_q}
		: (setup_dec.idx == 2'h1) ? {24'h0, debug_q}
		: (setup_dec.idx == 2'h2) ? {24'h0, ctrl_q}
		: {24'h0, stat_rd};

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cause_q <= `RSQ_CAUSE_RST;
			debug_q <= `RSQ_DEBUG_PIN_RST;
			ctrl_q <= `RSQ_CTRL_RST;
			// Power-on leaves RAM contents undefined
			ram_sus_q <= 1'b1;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			cause_q <= cause_d;
			debug_q <= debug_d;
			ctrl_q <= ctrl_d;
			ram_sus_q <= ram_sus_d;
			if (setup)
			begin
				prdata <= (setup_dec.valid && !pwrite) ? rd_mux : 32'h00000000;
				pslverr <= !setup_dec.valid;
			end
		end
	end

endmodule

// file: src/rsq_regs.svh
`ifndef RSQ_REGS_SVH
`define RSQ_REGS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define RSQ_CAUSE_OFFS 12'h000
`define RSQ_DEBUG_OFFS 12'h004
`define RSQ_CTRL_OFFS 12'h008
`define RSQ_STAT_OFFS 12'h00C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSQ_CAUSE_WDT_BIT 4
`define RSQ_CAUSE_CLM_BIT 1
`define RSQ_CAUSE_LVI_BIT 0
`define RSQ_CAUSE_MASK 8'h13
`define RSQ_DEBUG_EN_BIT 0
`define RSQ_CTRL_WDT_MODE_BIT 0
`define RSQ_CTRL_DIV_LSB 4
`define RSQ_STAT_RAM_BIT 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RSQ_CAUSE_RST 8'h00
`define RSQ_DEBUG_PIN_RST 8'h01
`define RSQ_CTRL_RST 8'h31
`define RSQ_DIV8 3'h3
`define RSQ_CPU_RESET_VEC 32'h00000000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSQ_CLK_NS 50
`define RSQ_FILT_NS 60
`define RSQ_FILT_CYCLES ((`RSQ_FILT_NS + `RSQ_CLK_NS - 1) / `RSQ_CLK_NS)
`define RSQ_STAB_CYCLES 1024
`define RSQ_WDT_HOLD_CYCLES 16

`endif

// file: src/rsq_pkg.sv
package rsq_pkg;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		RSQ_ST_PIN_HOLD = 2'b00,
		RSQ_ST_WDT_HOLD = 2'b01,
		RSQ_ST_STAB = 2'b10,
		RSQ_ST_RUN = 2'b11
	} rsq_state_e;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed
	{
		logic main_osc_en;
		logic int_osc_en;
		logic sub_osc_en;
		logic rtc_run;
		logic periph_clk_en;
		logic sys_clk_en;
		logic [2:0] cpu_div;
	} rsq_clk_ctl_s;

	typedef struct packed
	{
		logic cpu_hold;
		logic cpu_start;
		logic [31:0] reset_vec;
	} rsq_cpu_ctl_s;

	typedef struct packed
	{
		logic valid;
		logic [1:0] idx;
	} rsq_dec_s;

endpackage

// file: tb/rsq_monitor.sv
`timescale 1ns/1ps
`include "rsq_regs.svh"
module rsq_monitor
	import rsq_pkg::*;
#(
	parameter int STAB_CYCLES = 1024
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB request
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	// Reset sources
	input wire logic ext_reset_n_pin,
	input wire logic watchdog_reset_request,
	input wire logic debug_reset_pin,
	// System controls
	input wire logic sys_reset_n,
	input wire logic io_hiz,
	input wire logic wdt_clear,
	input wire logic wdt_run,
	input wire logic debug_mode_entry,
	input wire rsq_clk_ctl_s clk_ctl,
	input wire rsq_cpu_ctl_s cpu_ctl
);
	logic [15:0] stab_q;
	logic mode_q;
	// Own copy of the reset-mode bit, as the register is out of sight here
	wire ctrl_wr = psel && penable && pwrite && paddr == `RSQ_CTRL_OFFS;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			stab_q <= 16'h0;
			mode_q <= 1'h1;
		end
		else
		begin
			stab_q <= sys_reset_n ? stab_q + {15'h0, cpu_ctl.cpu_hold} : 16'h0;
			mode_q <= sys_reset_n ? (ctrl_wr ? pwdata[0] : mode_q) : 1'h1;
		end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_wdt_req; watchdog_reset_request && mode_q && sys_reset_n && ext_reset_n_pin; endsequence
	sequence s_hold; !sys_reset_n && io_hiz && wdt_clear; endsequence
	property p_hiz; io_hiz == !sys_reset_n; endproperty
	property p_osc; clk_ctl.main_osc_en == sys_reset_n && clk_ctl.int_osc_en == sys_reset_n
		&& clk_ctl.sub_osc_en && clk_ctl.rtc_run; endproperty
	property p_clk; clk_ctl.periph_clk_en == !cpu_ctl.cpu_hold && clk_ctl.sys_clk_en == !cpu_ctl.cpu_hold; endproperty
	property p_hold; !sys_reset_n |-> cpu_ctl.cpu_hold && clk_ctl.cpu_div == `RSQ_DIV8 && wdt_clear && !wdt_run;
		endproperty
	property p_wdt; s_wdt_req |-> ##[1:3] s_hold; endproperty
	property p_start; cpu_ctl.cpu_start |-> (!cpu_ctl.cpu_hold && clk_ctl.cpu_div == `RSQ_DIV8
		&& cpu_ctl.reset_vec == `RSQ_CPU_RESET_VEC) ##1 !cpu_ctl.cpu_start; endproperty
	property p_stab; $fell(cpu_ctl.cpu_hold) |-> stab_q >= STAB_CYCLES && stab_q <= STAB_CYCLES + 1; endproperty
	property p_dbg; $rose(debug_mode_entry) |-> sys_reset_n && $past(debug_reset_pin); endproperty
	property p_wdt_run; wdt_run == sys_reset_n && wdt_clear == !sys_reset_n; endproperty

	a_hiz: assert property (p_hiz) else $error("io_hiz off");
	a_osc: assert property (p_osc) else $error("oscillator enables off");
	a_clk: assert property (p_clk) else $error("clock enables off");
	a_hold: assert property (p_hold) else $error("hold outputs off");
	a_wdt: assert property (p_wdt) else $error("watchdog request ignored");
	a_start: assert property (p_start) else $error("cpu start off");
	a_stab: assert property (p_stab) else $error("stabilisation length off");
	a_dbg: assert property (p_dbg) else $error("debug entry off");
	a_wdt_run: assert property (p_wdt_run) else $error("watchdog run off");
endmodule

bind rsq_top rsq_monitor #(.STAB_CYCLES(STAB_CYCLES)) u_mon (.pclk(pclk), .presetn(presetn), .paddr(paddr),
	.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .ext_reset_n_pin(ext_reset_n_pin),
	.watchdog_reset_request(watchdog_reset_request), .debug_reset_pin(debug_reset_pin),
	.sys_reset_n(sys_reset_n), .io_hiz(io_hiz), .wdt_clear(wdt_clear), .wdt_run(wdt_run),
	.debug_mode_entry(debug_mode_entry), .clk_ctl(clk_ctl), .cpu_ctl(cpu_ctl));

// file: tb/rsq_partner.sv
`timescale 1ns/1ps
module rsq_partner
(
	// Clock
	input wire logic pclk,
	// Reset sources
	output logic ext_reset_n_pin,
	output logic watchdog_reset_request
);
	initial
	begin
		ext_reset_n_pin = 1'h1;
		watchdog_reset_request = 1'h0;
	end

	// Called just after an edge; the pin keeps its level for n clocks
	task automatic drive_pin(input logic v, input int n);
		ext_reset_n_pin <= v;
		repeat (n) @(posedge pclk);
	endtask

	// Overflow request is one clock wide
	task automatic wdt_fire();
		watchdog_reset_request <= 1'h1;
		@(posedge pclk);
		watchdog_reset_request <= 1'h0;
	endtask
endmodule

// file: tb/tb_rsq_top.sv
`timescale 1ns/1ps
`include "rsq_regs.svh"
module tb_rsq_top
	import rsq_pkg::*;
;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic lv = 1'h0, clm = 1'h0, dbg = 1'h0, mem = 1'h0, pready, pslverr, srn, hiz, ent, pin, wreq;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	rsq_clk_ctl_s clk_ctl;
	rsq_cpu_ctl_s cpu_ctl;
	int fails = 0, compares = 0;

	rsq_top #(.STAB_CYCLES(8), .WDT_HOLD_CYCLES(4)) DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .ext_reset_n_pin(pin), .watchdog_reset_request(wreq), .low_voltage_event(lv),
		.clock_monitor_event(clm), .debug_reset_pin(dbg), .cpu_mem_access(mem), .sys_reset_n(srn),
		.io_hiz(hiz), .wdt_clear(), .wdt_run(), .debug_mode_entry(ent), .clk_ctl(clk_ctl), .cpu_ctl(cpu_ctl));
	rsq_partner u_prt (.pclk(pclk), .ext_reset_n_pin(pin), .watchdog_reset_request(wreq));

	initial
		forever #25 pclk = ~pclk;

	task automatic report_and_stop();
		$display("Compares %0d, mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
		end
	endtask

	task automatic chk1(input string nm, input logic e, input logic g);
		chk(nm, {31'h0, e}, {31'h0, g});
	endtask

	// A set event may ride on the access phase to meet the write
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d, input logic ev);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		lv <= ev;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 20);
		rd = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
		lv <= 1'h0;
		if (pready !== 1'h1)
		begin
			fails++;
			report_and_stop();
		end
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] e, input string nm);
		apb(a, 1'h0, 32'h0, 1'h0);
		chk(nm, e, rd);
	endtask

	task automatic wait_start();
		int n;
		n = 0;
		while (cpu_ctl.cpu_start !== 1'h1 && n < 200)
		begin
			@(posedge pclk);
			n++;
		end
		if (cpu_ctl.cpu_start !== 1'h1)
		begin
			fails++;
			report_and_stop();
		end
	endtask

	initial
	begin
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		wait_start();
		rc(`RSQ_CAUSE_OFFS, 32'h0, "cause");
		rc(`RSQ_DEBUG_OFFS, 32'h1, "debug");
		rc(`RSQ_CTRL_OFFS, 32'h31, "ctrl");
		rc(`RSQ_STAT_OFFS, 32'h33, "status");
		apb(`RSQ_STAT_OFFS, 1'h1, 32'h1, 1'h0);
		rc(`RSQ_STAT_OFFS, 32'h32, "status");
		apb(12'h010, 1'h0, 32'h0, 1'h0);
		chk1("pslverr", 1'h1, pslverr);
		$display("Test power-up done");
		u_prt.drive_pin(1'h0, 1);
		u_prt.drive_pin(1'h1, 8);
		chk1("cpu_hold", 1'h0, cpu_ctl.cpu_hold);
		$display("Test pin filter done");
		apb(`RSQ_DEBUG_OFFS, 1'h1, 32'h0, 1'h0);
		apb(`RSQ_CTRL_OFFS, 1'h1, 32'h51, 1'h0);
		rc(`RSQ_CTRL_OFFS, 32'h51, "ctrl");
		apb(`RSQ_STAT_OFFS, 1'h0, 32'h0, 1'h1);
		rc(`RSQ_CAUSE_OFFS, 32'h1, "cause");
		u_prt.wdt_fire();
		repeat (3) @(posedge pclk);
		chk1("sys_reset_n", 1'h0, srn);
		wait_start();
		rc(`RSQ_CAUSE_OFFS, 32'h11, "cause");
		rc(`RSQ_DEBUG_OFFS, 32'h0, "debug");
		rc(`RSQ_CTRL_OFFS, 32'h31, "ctrl");
		$display("Test watchdog reset done");
		apb(`RSQ_CAUSE_OFFS, 1'h1, 32'h10, 1'h0);
		rc(`RSQ_CAUSE_OFFS, 32'h10, "cause");
		apb(`RSQ_CAUSE_OFFS, 1'h1, 32'h0, 1'h1);
		rc(`RSQ_CAUSE_OFFS, 32'h1, "cause");
		// Clock monitor event only records its own flag
		clm <= 1'h1;
		@(posedge pclk);
		clm <= 1'h0;
		rc(`RSQ_CAUSE_OFFS, 32'h3, "cause");
		$display("Test cause clear done");
		apb(`RSQ_CTRL_OFFS, 1'h1, 32'h30, 1'h0);
		u_prt.wdt_fire();
		repeat (6) @(posedge pclk);
		chk1("sys_reset_n", 1'h1, srn);
		dbg <= 1'h1;
		repeat (8) @(posedge pclk);
		chk1("debug entry", 1'h0, ent);
		$display("Test refused requests done");
		mem <= 1'h1;
		u_prt.drive_pin(1'h0, 8);
		chk1("sys_reset_n", 1'h0, srn);
		chk1("io_hiz", 1'h1, hiz);
		chk1("main osc", 1'h0, clk_ctl.main_osc_en);
		mem <= 1'h0;
		u_prt.drive_pin(1'h1, 0);
		wait_start();
		rc(`RSQ_DEBUG_OFFS, 32'h1, "debug");
		rc(`RSQ_CAUSE_OFFS, 32'h0, "cause");
		rc(`RSQ_STAT_OFFS, 32'h37, "status");
		$display("Test pin reset done");
		report_and_stop();
	end
endmodule
